// ==== design/cis_pkg.sv ====
// Shared constants and types for the CAN init and sleep control block
package cis_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_MCR = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRR = 8'h08;
  localparam logic [7:0] OFS_IMR = 8'h0C;
  localparam logic [7:0] OFS_MBDIR0 = 8'h10;
  localparam logic [7:0] OFS_MBDIR1 = 8'h14;

  // Master control register fields
  localparam int MCR_CFG = 0;
  localparam int MCR_TXORD = 1;
  localparam int MCR_SLEEP = 5;
  localparam int MCR_WAKE = 7;
  localparam logic [31:0] MCR_MASK = 32'h0000_00A3;
  localparam logic [31:0] MCR_RST = 32'h0000_0001;

  // Interrupt flag and mask fields (same layout)
  localparam int IRR_RST = 0;
  localparam int IRR_BUS = 12;
  localparam logic [31:0] IRR_MASK = 32'h0000_1001;
  localparam logic [31:0] IRR_RST_VAL = 32'h0000_0001;
  localparam logic [31:0] IMR_RST_VAL = 32'h0000_1001;

  // Mailbox direction: bits 15..1 are mailboxes 1..15, 0 = transmit
  localparam int MB_PER_CH = 15;
  localparam logic [31:0] MBDIR_MASK = 32'h0000_FFFE;
  localparam logic [31:0] MBDIR_RST = 32'h0000_0000;

  // Status register fields
  localparam int STAT_SLEEP = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_COMM = 2;
  localparam int STAT_DROP = 3;

  // Recessive run length that ends resynchronisation
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] RECESSIVE_BITS = 4'hB;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sleep sequencer states, Gray along awake-pend-sleep-resync
  typedef enum logic [1:0] {
    ST_AWAKE = 2'h0,
    ST_PEND = 2'h1,
    ST_SLEEP = 2'h3,
    ST_RESYNC = 2'h2
  } cis_state_t;

endpackage

// ==== design/cis_rx_monitor.sv ====
// CAN receive line synchroniser, change detector and recessive run counter
`timescale 1ns/1ps
module cis_rx_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus side
  input wire logic can_rx,
  input wire logic bit_tick,
  // Control and results
  input wire logic restart,
  output logic rx_level,
  output logic rx_change,
  output logic run_done
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic change;
    logic [cis_pkg::CNT_W-1:0] cnt;
    logic done;
  } cis_mon_t;

  cis_mon_t st;
  cis_mon_t nx;

  // Three-stage sync; a change counts once stages two and three agree
  always_comb begin
    nx = st;
    nx.s1 = can_rx;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.change = 1'b0;
    if (st.s2 == st.s3 && st.s3 != st.level) begin
      nx.level = st.s3;
      nx.change = 1'b1;
    end
    // Restart wins so a fresh wake never inherits an old run
    if (restart) begin
      nx.cnt = '0;
    end else if (bit_tick) begin
      if (!st.level) begin
        nx.cnt = '0;
      end else if (st.cnt != cis_pkg::RECESSIVE_BITS) begin
        nx.cnt = st.cnt + 4'h1;
      end
    end
    nx.done = (nx.cnt == cis_pkg::RECESSIVE_BITS);
  end

  // Line idles recessive after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.s1 <= 1'b1;
      st.s2 <= 1'b1;
      st.s3 <= 1'b1;
      st.level <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign rx_level = st.level;
  assign rx_change = st.change;
  assign run_done = st.done;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DOMINANT_RESTART: assert property (
    (bit_tick && !st.level) |=> (st.cnt == 4'h0 && !run_done))
    else $error("dominant bit did not restart the recessive count");

  AST_COUNT_STEP: assert property (
    (bit_tick && st.level && !restart && st.cnt < cis_pkg::RECESSIVE_BITS)
      |=> (st.cnt == $past(st.cnt) + 4'h1))
    else $error("recessive bit did not advance the count");

endmodule

// ==== design/cis_ctrl.sv ====
// CAN init and sleep control: AXI4-Lite registers, sleep sequencer, interrupts
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Reset flag is set after power-on reset and after standby recovery.
// - Fifteen mailboxes per channel, two channels, each transmit or receive.
// - A mailbox whose direction bit is 0 transmits.
// - Transmit order selectable: by identifier priority or by mailbox number.
// - Writing 1 to the sleep request bit asks for sleep mode.
// - Sleep entry waits while the bus is active, until it is idle.
// - Wake method bit picks software-only wake or also bus-activity wake.
// - Writing 0 to the sleep request bit leaves sleep mode.
// - With bus wake selected, a bus change ends sleep on its own.
// - The message that caused a bus wake is not stored.
// - Communication resumes only after eleven recessive bits following wake.
// - A bus change during sleep sets the bus-activity flag.
// - Bus-activity flag reaches the CPU only when its mask enables it.
module cis_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CAN line and bit timing
  input wire logic can_rx,
  input wire logic bit_tick,
  // System events
  input wire logic standby_exit,
  // Controls to the CAN core
  output logic irq,
  output logic sleep_mode,
  output logic comm_enable,
  output logic config_mode,
  output logic tx_order_mailbox,
  output logic wake_msg_discard,
  output logic [cis_pkg::MB_PER_CH:1] mb_dir_ch0,
  output logic [cis_pkg::MB_PER_CH:1] mb_dir_ch1
);

  typedef struct packed {
    cis_pkg::cis_state_t fsm;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] master_control_reg;
    logic [31:0] irq_flag_reg;
    logic [31:0] irq_mask_reg;
    logic [31:0] mbdir0;
    logic [31:0] mbdir1;
    logic irq;
    logic sleep;
    logic comm;
    logic drop;
  } cis_regs_t;

  cis_regs_t st;
  cis_regs_t nx;
  logic wr_fire;
  logic rd_fire;
  logic rd_irr;
  logic restart;
  logic rx_level;
  logic rx_change;
  logic run_done;
  logic [31:0] irr_set;
  logic [31:0] irr_clr;
  logic [31:0] stat;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] cis_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Line watcher; restart is combinational so the count clears on the wake edge
  cis_rx_monitor u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .can_rx(can_rx),
    .bit_tick(bit_tick),
    .restart(restart),
    .rx_level(rx_level),
    .rx_change(rx_change),
    .run_done(run_done)
  );

  // Next-state logic: bus slave, register file, sleep sequencer, interrupts
  always_comb begin
    nx = st;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    rd_irr = 1'b0;
    irr_set = '0;
    irr_clr = '0;
    stat = '0;
    stat[cis_pkg::STAT_SLEEP] = st.sleep;
    stat[cis_pkg::STAT_PEND] = (st.fsm == cis_pkg::ST_PEND);
    stat[cis_pkg::STAT_COMM] = st.comm;
    stat[cis_pkg::STAT_DROP] = st.drop;

    // Address and data are caught independently, in either order
    if (st.awready && s_axi_awvalid) begin
      nx.aw_held = 1'b1;
      nx.aw_addr = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid) begin
      nx.w_held = 1'b1;
      nx.w_data = s_axi_wdata;
      nx.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      wr_fire = 1'b1;
      nx.aw_held = 1'b0;
      nx.w_held = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = cis_pkg::RESP_OKAY;
      case (st.aw_addr)
        cis_pkg::OFS_MCR: begin
          nx.master_control_reg = cis_merge(st.master_control_reg, st.w_data, st.w_strb) & cis_pkg::MCR_MASK;
        end
        cis_pkg::OFS_IMR: begin
          nx.irq_mask_reg = cis_merge(st.irq_mask_reg, st.w_data, st.w_strb) & cis_pkg::IRR_MASK;
        end
        cis_pkg::OFS_MBDIR0: begin
          nx.mbdir0 = cis_merge(st.mbdir0, st.w_data, st.w_strb) & cis_pkg::MBDIR_MASK;
        end
        cis_pkg::OFS_MBDIR1: begin
          nx.mbdir1 = cis_merge(st.mbdir1, st.w_data, st.w_strb) & cis_pkg::MBDIR_MASK;
        end
        cis_pkg::OFS_STAT, cis_pkg::OFS_IRR: begin
          nx.bresp = cis_pkg::RESP_OKAY; // Read-only, write ignored
        end
        default: begin
          nx.bresp = cis_pkg::RESP_SLVERR;
        end
      endcase
    end
    nx.awready = !nx.aw_held && !nx.bvalid;
    nx.wready = !nx.w_held && !nx.bvalid;

    // Read channel; a read of the flag register clears what it returned
    if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
    if (st.arready && s_axi_arvalid) begin
      rd_fire = 1'b1;
      nx.rvalid = 1'b1;
      nx.rresp = cis_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cis_pkg::OFS_MCR: nx.rdata = st.master_control_reg;
        cis_pkg::OFS_STAT: nx.rdata = stat;
        cis_pkg::OFS_IRR: begin
          nx.rdata = st.irq_flag_reg;
          rd_irr = 1'b1;
          irr_clr = st.irq_flag_reg;
        end
        cis_pkg::OFS_IMR: nx.rdata = st.irq_mask_reg;
        cis_pkg::OFS_MBDIR0: nx.rdata = st.mbdir0;
        cis_pkg::OFS_MBDIR1: nx.rdata = st.mbdir1;
        default: begin
          nx.rdata = '0;
          nx.rresp = cis_pkg::RESP_SLVERR;
        end
      endcase
    end
    nx.arready = !nx.rvalid;

    // Sleep sequencer follows the request bit as it stands after this write
    case (st.fsm)
      cis_pkg::ST_AWAKE: begin
        if (nx.master_control_reg[cis_pkg::MCR_SLEEP]) begin
          nx.fsm = run_done ? cis_pkg::ST_SLEEP : cis_pkg::ST_PEND;
        end
      end
      cis_pkg::ST_PEND: begin
        if (!nx.master_control_reg[cis_pkg::MCR_SLEEP]) begin
          nx.fsm = cis_pkg::ST_AWAKE;
        end else if (run_done) begin
          nx.fsm = cis_pkg::ST_SLEEP;
        end
      end
      cis_pkg::ST_SLEEP: begin
        if (rx_change) begin
          irr_set[cis_pkg::IRR_BUS] = 1'b1;
        end
        if (!nx.master_control_reg[cis_pkg::MCR_SLEEP]) begin
          nx.fsm = cis_pkg::ST_RESYNC;
        end else if (st.master_control_reg[cis_pkg::MCR_WAKE] && rx_change) begin
          // Hardware drops the request itself so software sees it awake
          nx.fsm = cis_pkg::ST_RESYNC;
          nx.master_control_reg[cis_pkg::MCR_SLEEP] = 1'b0;
          nx.drop = 1'b1;
        end
      end
      cis_pkg::ST_RESYNC: begin
        if (run_done) begin
          nx.fsm = cis_pkg::ST_AWAKE;
        end
      end
      default: nx.fsm = cis_pkg::ST_AWAKE;
    endcase

    // Event set wins over a read clear in the same cycle
    if (standby_exit) begin
      irr_set[cis_pkg::IRR_RST] = 1'b1;
    end
    nx.irq_flag_reg = ((st.irq_flag_reg & ~irr_clr) | irr_set) & cis_pkg::IRR_MASK;

    // Waking frame is discarded until the recessive run completes
    if (nx.fsm == cis_pkg::ST_AWAKE) begin
      nx.drop = 1'b0;
    end
    nx.sleep = (nx.fsm == cis_pkg::ST_SLEEP);
    nx.comm = (nx.fsm == cis_pkg::ST_AWAKE) && !nx.master_control_reg[cis_pkg::MCR_CFG];
    // Mask bit 1 blocks; level output while any enabled flag is set
    nx.irq = |(nx.irq_flag_reg & ~nx.irq_mask_reg);
  end

  assign restart = (st.fsm == cis_pkg::ST_SLEEP) && (nx.fsm == cis_pkg::ST_RESYNC);

  // Synchronous reset; reset flag comes up set after power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.master_control_reg <= cis_pkg::MCR_RST;
      st.irq_flag_reg <= cis_pkg::IRR_RST_VAL;
      st.irq_mask_reg <= cis_pkg::IMR_RST_VAL;
      st.mbdir0 <= cis_pkg::MBDIR_RST;
      st.mbdir1 <= cis_pkg::MBDIR_RST;
      st.fsm <= cis_pkg::ST_AWAKE;
    end else begin
      st <= nx;
    end
  end

  // Every output is a flop bit of the state
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign irq = st.irq;
  assign sleep_mode = st.sleep;
  assign comm_enable = st.comm;
  assign config_mode = st.master_control_reg[cis_pkg::MCR_CFG];
  assign tx_order_mailbox = st.master_control_reg[cis_pkg::MCR_TXORD];
  assign wake_msg_discard = st.drop;
  assign mb_dir_ch0 = st.mbdir0[cis_pkg::MB_PER_CH:1];
  assign mb_dir_ch1 = st.mbdir1[cis_pkg::MB_PER_CH:1];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_bus_wake;
    st.fsm == cis_pkg::ST_SLEEP && st.master_control_reg[cis_pkg::MCR_WAKE] && rx_change;
  endsequence

  sequence s_wake_done;
    st.fsm == cis_pkg::ST_RESYNC ##1 st.fsm == cis_pkg::ST_AWAKE;
  endsequence

  AST_STANDBY_FLAG: assert property (
    standby_exit |=> st.irq_flag_reg[cis_pkg::IRR_RST])
    else $error("standby exit did not set the reset flag");

  AST_SLEEP_REQ: assert property (
    (wr_fire && st.aw_addr == cis_pkg::OFS_MCR && st.w_strb[0]
      && st.w_data[cis_pkg::MCR_SLEEP] && st.fsm == cis_pkg::ST_AWAKE && !run_done)
      |=> st.fsm == cis_pkg::ST_PEND)
    else $error("sleep request on a busy bus did not go pending");

  AST_SLEEP_WAITS_IDLE: assert property (
    (st.fsm != cis_pkg::ST_SLEEP ##1 st.fsm == cis_pkg::ST_SLEEP) |-> $past(run_done))
    else $error("sleep entered while the bus was active");

  AST_SW_ONLY_WAKE: assert property (
    (st.fsm == cis_pkg::ST_SLEEP && !st.master_control_reg[cis_pkg::MCR_WAKE] && !wr_fire)
      |=> st.fsm == cis_pkg::ST_SLEEP)
    else $error("left sleep without software in software-wake mode");

  AST_SW_WAKE: assert property (
    (wr_fire && st.aw_addr == cis_pkg::OFS_MCR && st.w_strb[0]
      && !st.w_data[cis_pkg::MCR_SLEEP] && st.fsm == cis_pkg::ST_SLEEP)
      |=> st.fsm == cis_pkg::ST_RESYNC && !st.comm)
    else $error("clearing the sleep bit did not wake the block");

  AST_BUS_WAKE: assert property (
    s_bus_wake |=> (st.fsm == cis_pkg::ST_RESYNC && !st.master_control_reg[cis_pkg::MCR_SLEEP]))
    else $error("bus activity did not end sleep");

  AST_DISCARD: assert property (
    s_bus_wake |=> st.drop until (st.fsm == cis_pkg::ST_AWAKE))
    else $error("waking frame was not discarded");

  AST_RESYNC_GATE: assert property (
    $rose(st.fsm == cis_pkg::ST_AWAKE) && $past(st.fsm == cis_pkg::ST_RESYNC)
      |-> $past(run_done))
    else $error("communication resumed before eleven recessive bits");

  AST_NO_COMM_RESYNC: assert property (
    s_wake_done |-> !$past(st.comm))
    else $error("communication enabled during resync");

  AST_BUS_FLAG: assert property (
    (st.fsm == cis_pkg::ST_SLEEP && rx_change) |=> st.irq_flag_reg[cis_pkg::IRR_BUS])
    else $error("bus change in sleep did not set the flag");

  AST_IRQ_LEVEL: assert property (
    st.irq == |(st.irq_flag_reg & ~st.irq_mask_reg))
    else $error("interrupt output does not match enabled flags");

  AST_FLAG_STICKY: assert property (
    (st.irq_flag_reg[cis_pkg::IRR_BUS] && !rd_irr) |=> st.irq_flag_reg[cis_pkg::IRR_BUS])
    else $error("bus flag dropped without a read");

endmodule

// ==== dv/cis_can_node.sv ====
// Behavioural CAN node model: bit timing ticks and random stuffed frames on the line
`timescale 1ns/1ps
module cis_can_node #(
  parameter int BIT_CYC = 6,
  parameter int FRAME_BITS = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Frame request from the bench
  input wire logic start,
  // Bus side
  output logic can_rx,
  output logic bit_tick,
  output logic busy
);
  int ph;
  int nbit;
  logic pend;

  // Line changes at phase 0; the tick sits on the last phase so the
  // receiver's synchroniser has settled before the bit is counted
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 0;
      nbit <= 0;
      pend <= 1'b0;
      busy <= 1'b0;
      can_rx <= 1'b1;
      bit_tick <= 1'b0;
    end else begin
      ph <= (ph == BIT_CYC - 1) ? 0 : ph + 1;
      bit_tick <= (ph == BIT_CYC - 2);
      if (ph == BIT_CYC - 1) begin
        if (nbit != 0) begin
          nbit <= nbit - 1;
          // Forced dominant every fifth bit and at the end: no idle run inside a frame
          can_rx <= (nbit % 5 == 1) ? 1'b0 : (($urandom % 2) != 0);
        end else if (pend) begin
          pend <= 1'b0;
          nbit <= FRAME_BITS - 1;
          can_rx <= 1'b0;
          busy <= 1'b1;
        end else begin
          // Released bus floats to recessive
          can_rx <= 1'b1;
          busy <= 1'b0;
        end
      end
      if (start) begin
        pend <= 1'b1;
      end
    end
  end
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the CAN init and sleep control block
`timescale 1ns/1ps
module testbench;
  localparam int BIT = 6;
  localparam int SL = 0;
  localparam int CE = 1;
  localparam int BZ = 2;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, can_rx, bit_tick, standby_exit, start, busy;
  logic irq, sleep_mode, comm_enable, config_mode, tx_order_mailbox, wake_msg_discard;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:1] mb_dir_ch0, mb_dir_ch1;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [31:0] dd[2];
  logic early;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;

  cis_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .can_rx(can_rx), .bit_tick(bit_tick), .standby_exit(standby_exit), .irq(irq),
    .sleep_mode(sleep_mode), .comm_enable(comm_enable), .config_mode(config_mode),
    .tx_order_mailbox(tx_order_mailbox), .wake_msg_discard(wake_msg_discard),
    .mb_dir_ch0(mb_dir_ch0), .mb_dir_ch1(mb_dir_ch1));

  cis_can_node #(.BIT_CYC(BIT), .FRAME_BITS(20)) node (.aclk(aclk), .aresetn(aresetn),
    .start(start), .can_rx(can_rx), .bit_tick(bit_tick), .busy(busy));

  // Clock at 20 MHz
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t ns: %s", $time, m);
  endtask

  task automatic chk(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask

  task automatic chkv(input logic [15:1] got, input logic [15:1] exp, input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] resp);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    exp_b.push_back(resp);
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (!w_d && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_r.push_back({resp, d});
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      SL: return sleep_mode;
      CE: return comm_enable;
      default: return busy;
    endcase
  endfunction

  // Bounded wait for a level; the following check judges the outcome
  task automatic wait_sig(input int s, input logic v, input int lim);
    for (int k = 0; k < lim && sig(s) !== v; k++) @(posedge aclk);
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask

  task automatic frame();
    @(posedge aclk);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    wait_sig(BZ, 1'b1, 4 * BIT);
    // Let the dominant start bit reach the recessive count before software acts
    repeat (2 * BIT) @(posedge aclk);
  endtask

  task automatic stop_test();
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Response monitor: oldest noted expectation against each completed transfer
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      n_tests++;
      if (exp_r.size() == 0) fail("unexpected read data");
      else if ({rresp, rdata} !== exp_r.pop_front()) fail("read data or response");
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      n_tests++;
      if (exp_b.size() == 0) fail("unexpected write response");
      else if (bresp !== exp_b.pop_front()) fail("write response");
    end
  end

  // Hang guard, far above the thousand or so cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      stop_test();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, standby_exit, start} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    void'($urandom(23917));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state, flag cleared first while still in configuration mode
    rd(cis_pkg::OFS_IRR, 32'h0000_0001, cis_pkg::RESP_OKAY);
    rd(cis_pkg::OFS_IRR, 32'h0000_0000, cis_pkg::RESP_OKAY);
    rd(cis_pkg::OFS_MCR, 32'h0000_0001, cis_pkg::RESP_OKAY);
    rd(cis_pkg::OFS_IMR, 32'h0000_1001, cis_pkg::RESP_OKAY);
    chk(config_mode, 1'b1, "config after reset");
    chk(comm_enable, 1'b0, "comm in config");
    // Random mailbox directions, both channels, bits outside the map dropped
    for (i = 0; i < 2; i++) begin
      dd[i] = $urandom;
      wr(i ? cis_pkg::OFS_MBDIR1 : cis_pkg::OFS_MBDIR0, dd[i], 4'hF, cis_pkg::RESP_OKAY);
      dd[i] = dd[i] & cis_pkg::MBDIR_MASK;
      rd(i ? cis_pkg::OFS_MBDIR1 : cis_pkg::OFS_MBDIR0, dd[i], cis_pkg::RESP_OKAY);
      chkv(i ? mb_dir_ch1 : mb_dir_ch0, dd[i][15:1], "mailbox direction");
    end
    // One byte lane only, then every channel 0 mailbox to transmit
    wr(cis_pkg::OFS_MBDIR0, 32'hFFFF_FFFF, 4'h2, cis_pkg::RESP_OKAY);
    rd(cis_pkg::OFS_MBDIR0, dd[0] | 32'h0000_FF00, cis_pkg::RESP_OKAY);
    wr(cis_pkg::OFS_MBDIR0, 32'h0000_0000, 4'hF, cis_pkg::RESP_OKAY);
    settle();
    chkv(mb_dir_ch0, 15'h0000, "all transmit");
    // Unmapped, unaligned and read-only places
    wr(8'h40, 32'h1234_5678, 4'hF, cis_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0000_0000, cis_pkg::RESP_SLVERR);
    rd(8'h02, 32'h0000_0000, cis_pkg::RESP_SLVERR);
    wr(cis_pkg::OFS_STAT, 32'hFFFF_FFFF, 4'hF, cis_pkg::RESP_OKAY);
    rd(cis_pkg::OFS_STAT, 32'h0000_0000, cis_pkg::RESP_OKAY);
    // Both transmit orders
    for (i = 0; i < 2; i++) begin
      wr(cis_pkg::OFS_MCR, {30'h0, i[0], 1'b1}, 4'hF, cis_pkg::RESP_OKAY);
      settle();
      chk(tx_order_mailbox, i[0], "transmit order");
    end
    wr(cis_pkg::OFS_MCR, 32'h0000_0000, 4'hF, cis_pkg::RESP_OKAY);
    wait_sig(CE, 1'b1, 20 * BIT);
    chk(comm_enable, 1'b1, "comm after config");
    // Sleep requested while a frame is on the bus
    frame();
    early = 1'b0;
    wr(cis_pkg::OFS_MCR, 32'h0000_0020, 4'hF, cis_pkg::RESP_OKAY);
    for (int k = 0; k < 40 * BIT && busy; k++) begin
      @(posedge aclk);
      early = early | sleep_mode;
    end
    repeat (10 * BIT) @(posedge aclk);
    chk(early | sleep_mode, 1'b0, "sleep while bus busy");
    wait_sig(SL, 1'b1, 4 * BIT);
    chk(sleep_mode, 1'b1, "sleep entry");
    // Bus change with software-only wake: flag set, masked, then enabled
    frame();
    wait_sig(BZ, 1'b0, 40 * BIT);
    chk(sleep_mode, 1'b1, "stays asleep");
    chk(irq, 1'b0, "masked activity");
    wr(cis_pkg::OFS_IMR, 32'h0000_0001, 4'hF, cis_pkg::RESP_OKAY);
    settle();
    chk(irq, 1'b1, "enabled activity");
    repeat (20) @(posedge aclk);
    chk(irq, 1'b1, "irq held");
    rd(cis_pkg::OFS_IRR, 32'h0000_1000, cis_pkg::RESP_OKAY);
    settle();
    chk(irq, 1'b0, "irq after clear");
    // Software wake, then a frame restarts the recessive count
    wr(cis_pkg::OFS_MCR, 32'h0000_0000, 4'hF, cis_pkg::RESP_OKAY);
    settle();
    chk(sleep_mode, 1'b0, "software wake");
    frame();
    early = comm_enable;
    for (int k = 0; k < 40 * BIT && busy; k++) begin
      @(posedge aclk);
      early = early | comm_enable;
    end
    repeat (10 * BIT) @(posedge aclk);
    chk(early | comm_enable, 1'b0, "comm before eleven recessive");
    wait_sig(CE, 1'b1, 4 * BIT);
    chk(comm_enable, 1'b1, "comm resumed");
    // Bus-activity wake
    wr(cis_pkg::OFS_MCR, 32'h0000_00A0, 4'hF, cis_pkg::RESP_OKAY);
    wait_sig(SL, 1'b1, 20 * BIT);
    frame();
    wait_sig(SL, 1'b0, 4 * BIT);
    chk(sleep_mode, 1'b0, "bus wake");
    chk(wake_msg_discard, 1'b1, "waking frame dropped");
    rd(cis_pkg::OFS_MCR, 32'h0000_0080, cis_pkg::RESP_OKAY);
    rd(cis_pkg::OFS_IRR, 32'h0000_1000, cis_pkg::RESP_OKAY);
    wait_sig(BZ, 1'b0, 40 * BIT);
    wait_sig(CE, 1'b1, 14 * BIT);
    chk(comm_enable, 1'b1, "comm after bus wake");
    chk(wake_msg_discard, 1'b0, "next frame received");
    // Standby recovery sets the reset flag again
    @(posedge aclk);
    standby_exit <= 1'b1;
    @(posedge aclk);
    standby_exit <= 1'b0;
    wr(cis_pkg::OFS_IMR, 32'h0000_1000, 4'hF, cis_pkg::RESP_OKAY);
    settle();
    chk(irq, 1'b1, "reset flag interrupt");
    rd(cis_pkg::OFS_IRR, 32'h0000_0001, cis_pkg::RESP_OKAY);
    settle();
    chk(irq, 1'b0, "reset flag cleared");
    stop_test();
  end
endmodule
